// ==== shared/wrop_pkg.sv ====
package wrop_pkg;

  // Word address reach of the data bus and the block granularity
  localparam int unsigned ADDR_W       = 22;
  localparam int unsigned BLK_LSB      = 6;
  localparam int unsigned BLK_W        = 16;

  // Register indices; the byte address on APB is four times the index
  localparam logic [11:0] DEV_CFG_IDX  = 12'h880;
  localparam logic [11:0] START_IDX    = 12'h884;
  localparam logic [11:0] SIZE_IDX     = 12'h885;
  localparam logic [11:0] STATUS_IDX   = 12'h888;
  localparam int unsigned PADDR_W      = 14;
  localparam logic [PADDR_W-1:0] DEV_CFG_ADDR = {DEV_CFG_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] START_ADDR   = {START_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] SIZE_ADDR    = {SIZE_IDX, 2'b00};
  localparam logic [PADDR_W-1:0] STATUS_ADDR  = {STATUS_IDX, 2'b00};

  // Reset values
  localparam logic [15:0] START_RST    = 16'h0100;
  localparam logic [15:0] SIZE_RST     = 16'h00ff;
  localparam logic [31:0] CFG_RST      = 32'h0008_0003;

  // Device configuration register layout
  localparam logic [31:0] CFG_WR_MASK  = 32'h0008_8083;
  localparam logic [31:0] CFG_RO_ONES  = 32'h0007_0040;
  localparam int unsigned CFG_MAP_BIT  = 3;
  localparam int unsigned CFG_RST_BIT  = 5;
  localparam int unsigned CFG_EN_BIT   = 19;

  // Status register layout
  localparam int unsigned ST_HELD_BIT  = 0;
  localparam int unsigned ST_STALL_BIT = 1;
  localparam int unsigned ST_CNT_LSB   = 16;

  typedef enum logic [1:0] {
    WROP_IDLE = 2'b01,
    WROP_HELD = 2'b10
  } wrop_fsm_t;

endpackage

// ==== design/wrop_region_match.sv ====
`timescale 1ns/1ps
module wrop_region_match (
  input  wire logic [wrop_pkg::ADDR_W-1:0] addr,
  input  wire logic [wrop_pkg::BLK_W-1:0]  start,
  input  wire logic [wrop_pkg::BLK_W-1:0]  size_mask,
  output logic                             hit
);

  // Ones in the mask are don't-care bits inside the block
  assign hit = (((addr[wrop_pkg::ADDR_W-1:wrop_pkg::BLK_LSB] ^ start) & ~size_mask)
                == '0); // [RULE_10] [RULE_04] [RULE_05]

endmodule

// ==== design/wrop_guard.sv ====
// Notes on behaviour
// RULE_01: With guard on, a read in the block waits until the earlier write issues.
// RULE_02: With guard off, reads may pass earlier writes to differing addresses.
// RULE_03: Same-address write then read is always ordered; guard adds differing addresses.
// RULE_04: Start register holds word address bits 21..6; one count is 64 words.
// RULE_05: Size register is a right-aligned mask; zero means 64 words, all ones 4M.
// RULE_06: Software must align the start to a multiple of the block size.
// RULE_07: Reset loads start 0x0100 and size 0x00ff.
// RULE_08: Default block spans word addresses 0x4000 up to 0x8000.
// RULE_09: Configuration bit 19 enables the guard and resets to one.
// RULE_10: Address is inside when bits 21..6 match start wherever the mask is zero.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module wrop_guard (
  input  wire logic                              clk,
  input  wire logic                              reset,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [wrop_pkg::PADDR_W-1:0]      paddr,
  input  wire logic [31:0]                       pwdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic [31:0]                            prdata,
  // Live device status shown in the configuration register
  input  wire logic                              vmap_status,
  input  wire logic                              reset_pin_status,
  // Pipeline side
  input  wire logic                              wr_accept,
  input  wire logic [wrop_pkg::ADDR_W-1:0]       wr_accept_addr,
  input  wire logic                              wr_issued,
  input  wire logic                              rd_req_valid,
  input  wire logic [wrop_pkg::ADDR_W-1:0]       rd_req_addr,
  output logic                                   rd_stall,
  output logic                                   order_guard_enable
);

  typedef struct packed {
    wrop_pkg::wrop_fsm_t                fsm;
    logic [wrop_pkg::ADDR_W-1:0]        wr_addr;
    logic [wrop_pkg::BLK_W-1:0]         start;
    logic [wrop_pkg::BLK_W-1:0]         size;
    logic [31:0]                        cfg;
    logic [31:0]                        rdata;
    logic                               slverr;
    logic [15:0]                        stall_cnt;
  } wrop_state_t;

  wrop_state_t st_q;
  wrop_state_t st_d;

  logic        wr_hit;
  logic        rd_hit;
  logic        same_addr;
  logic        guard_stall;
  logic        setup_ph;
  logic        access_wr;
  logic [31:0] cfg_view;
  logic [31:0] status_view;

  ////////////////////////////////////////////////////////////////////////////
  // Region compare for the held write and the incoming read

  wrop_region_match u_wr_match (
    .addr      (st_q.wr_addr),
    .start     (st_q.start),
    .size_mask (st_q.size),
    .hit       (wr_hit)
  );

  wrop_region_match u_rd_match (
    .addr      (rd_req_addr),
    .start     (st_q.start),
    .size_mask (st_q.size),
    .hit       (rd_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ordering decision

  assign order_guard_enable = st_q.cfg[wrop_pkg::CFG_EN_BIT]; // [RULE_09]
  assign same_addr = (rd_req_addr == st_q.wr_addr);

  // Region ordering only when enabled; otherwise reads take pipeline order
  assign guard_stall = order_guard_enable & wr_hit & rd_hit; // [RULE_01] [RULE_02]

  // Stall lasts through the issue cycle, so the read leaves one cycle after it
  assign rd_stall = (st_q.fsm == wrop_pkg::WROP_HELD) & rd_req_valid
                    & (same_addr | guard_stall); // [RULE_03] [RULE_01]

  ////////////////////////////////////////////////////////////////////////////
  // Register views

  always_comb begin
    cfg_view = (st_q.cfg & wrop_pkg::CFG_WR_MASK) | wrop_pkg::CFG_RO_ONES;
    cfg_view[wrop_pkg::CFG_MAP_BIT] = vmap_status;
    cfg_view[wrop_pkg::CFG_RST_BIT] = reset_pin_status;
    status_view = '0;
    status_view[wrop_pkg::ST_HELD_BIT]  = (st_q.fsm == wrop_pkg::WROP_HELD);
    status_view[wrop_pkg::ST_STALL_BIT] = rd_stall;
    status_view[wrop_pkg::ST_CNT_LSB +: 16] = st_q.stall_cnt;
  end

  assign setup_ph  = psel & ~penable;
  assign access_wr = psel & penable & pwrite;

  // Zero wait states: read data is loaded during setup
  assign pready  = 1'b1;
  assign pslverr = psel & penable & st_q.slverr;
  assign prdata  = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d = st_q;

    // Write tracking: one write outstanding at a time from the pipeline
    case (st_q.fsm)
      wrop_pkg::WROP_IDLE: begin
        if (wr_accept) begin
          st_d.fsm     = wrop_pkg::WROP_HELD;
          st_d.wr_addr = wr_accept_addr;
        end
      end
      wrop_pkg::WROP_HELD: begin
        if (wr_accept) begin
          st_d.wr_addr = wr_accept_addr;
        end else if (wr_issued) begin
          st_d.fsm = wrop_pkg::WROP_IDLE; // [RULE_01]
        end
      end
      default: begin
        st_d.fsm = wrop_pkg::WROP_IDLE;
      end
    endcase

    // Saturating count of stalled read cycles, for software visibility
    if (rd_stall && st_q.stall_cnt != 16'hffff) begin
      st_d.stall_cnt = st_q.stall_cnt + 16'h0001;
    end

    if (setup_ph) begin
      st_d.rdata  = '0;
      st_d.slverr = 1'b0;
      case (paddr)
        wrop_pkg::DEV_CFG_ADDR: st_d.rdata = cfg_view;
        wrop_pkg::START_ADDR:   st_d.rdata = {16'h0000, st_q.start};
        wrop_pkg::SIZE_ADDR:    st_d.rdata = {16'h0000, st_q.size};
        wrop_pkg::STATUS_ADDR:  st_d.rdata = status_view;
        default:                st_d.slverr = 1'b1;
      endcase
    end

    if (access_wr) begin
      case (paddr)
        wrop_pkg::DEV_CFG_ADDR: st_d.cfg = pwdata & wrop_pkg::CFG_WR_MASK; // [RULE_09]
        wrop_pkg::START_ADDR:   st_d.start = pwdata[15:0]; // [RULE_04]
        wrop_pkg::SIZE_ADDR:    st_d.size = pwdata[15:0]; // [RULE_05]
        // Writing the status register clears the stall counter
        wrop_pkg::STATUS_ADDR:  st_d.stall_cnt = 16'h0000;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q.fsm       <= wrop_pkg::WROP_IDLE;
      st_q.wr_addr   <= '0;
      st_q.start     <= wrop_pkg::START_RST; // [RULE_07] [RULE_08]
      st_q.size      <= wrop_pkg::SIZE_RST; // [RULE_07] [RULE_08]
      st_q.cfg       <= wrop_pkg::CFG_RST; // [RULE_09]
      st_q.rdata     <= '0;
      st_q.slverr    <= 1'b0;
      st_q.stall_cnt <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ==== sim/wrop_guard_assertions.sv ====
`timescale 1ns/1ps
module wrop_guard_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        wr_accept,
  input wire logic [21:0] wr_accept_addr,
  input wire logic        wr_issued,
  input wire logic        rd_req_valid,
  input wire logic [21:0] rd_req_addr,
  input wire logic        rd_stall,
  input wire logic        order_guard_enable
);
  logic        held_q;
  logic [21:0] wa_q;
  logic [15:0] st_q;
  logic [15:0] sz_q;
  logic        wc;
  logic        hs;
  logic        ib;
  assign wc = psel && penable && pwrite;
  assign hs = held_q && rd_req_valid;
  assign ib = (((rd_req_addr[21:6] ^ st_q) | (wa_q[21:6] ^ st_q)) & ~sz_q) == 16'h0000;
  // Shadow of the block registers so the hit test does not trust the design
  always_ff @(posedge clk) begin
    held_q <= !reset && (wr_accept || (held_q && !wr_issued));
    wa_q <= wr_accept ? wr_accept_addr : wa_q;
    st_q <= reset ? 16'h0100 : (wc && paddr == 14'h2210) ? pwdata[15:0] : st_q;
    sz_q <= reset ? 16'h00ff : (wc && paddr == 14'h2214) ? pwdata[15:0] : sz_q;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_en_after_reset: assert property ($fell(reset) |-> order_guard_enable)
    else $error("enable low after reset");
  a_en_follows_write: assert property (wc && paddr == 14'h2200 |=>
    order_guard_enable == $past(pwdata[19])) else $error("enable bit not taken");
  a_same_addr_stall: assert property (hs && rd_req_addr == wa_q |-> rd_stall)
    else $error("same address read not held");
  a_idle_no_stall: assert property (rd_req_valid && !held_q |-> !rd_stall)
    else $error("stall with no write pending");
  a_off_passes: assert property (hs && !order_guard_enable && rd_req_addr != wa_q
    |-> !rd_stall) else $error("stall while guard off");
  a_block_stall: assert property (hs && order_guard_enable && ib |-> rd_stall)
    else $error("in-block read not held");
  a_outside_passes: assert property (hs && rd_req_addr != wa_q && !ib |-> !rd_stall)
    else $error("out-of-block read held");
  a_issue_drop: assert property (held_q && wr_issued && !wr_accept ##1 rd_req_valid
    |-> !rd_stall) else $error("stall after write issued");
  cover property (hs && rd_stall);
  cover property (hs && !order_guard_enable);
  cover property (wc && paddr == 14'h2214);
endmodule

// ==== sim/wrop_pipe_model.sv ====
`timescale 1ns/1ps
module wrop_pipe_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [7:0]  lat,
  input  wire logic [21:0] waddr,
  input  wire logic [21:0] raddr,
  input  wire logic        rd_stall,
  output logic             wr_accept = 1'b0,
  output logic [21:0]      wr_accept_addr = 22'h0,
  output logic             wr_issued = 1'b0,
  output logic             rd_req_valid = 1'b0,
  output logic [21:0]      rd_req_addr = 22'h0
);
  logic [7:0] cnt = 8'h00;
  // Idle address lines toggle so a stale value never looks like a request
  always @(posedge clk) begin
    wr_accept <= go;
    wr_accept_addr <= go ? waddr : ~wr_accept_addr;
    cnt <= go ? lat : (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    wr_issued <= (cnt == 8'h01);
    rd_req_valid <= wr_accept || (rd_req_valid && rd_stall);
    rd_req_addr <= (wr_accept || (rd_req_valid && rd_stall)) ? raddr : ~rd_req_addr;
  end
endmodule

// ==== sim/wrop_guard_tb_top.sv ====
`timescale 1ns/1ps
module wrop_guard_tb_top;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, go = 0, vmap_status = 1;
  logic reset_pin_status = 0, pready, pslverr, wr_accept, wr_issued, rd_req_valid, rd_stall;
  logic order_guard_enable, err;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [21:0] waddr = 22'h0, raddr = 22'h0, wr_accept_addr, rd_req_addr;
  logic [7:0]  lat = 8'h02;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  wrop_guard i_wrop_guard (.*);
  wrop_pipe_model i_wrop_pipe_model (.*);
  always #5 clk = ~clk;
  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic rw(input logic [21:0] w, input logic [21:0] r, input logic [7:0] l, input logic e);
    waddr <= w; raddr <= r; lat <= l; go <= 1;
    @(posedge clk) go <= 0;
    @(posedge clk);
    #1 chk(rd_stall, e);
    repeat (14) @(posedge clk);
  endtask
  task automatic t_reset;
    apb(0, wrop_pkg::START_ADDR, 0);
    chk(rd, 32'h0000_0100);
    apb(0, wrop_pkg::SIZE_ADDR, 0);
    chk(rd, 32'h0000_00ff);
    apb(0, wrop_pkg::DEV_CFG_ADDR, 0);
    chk(rd, 32'h000f_004b);
  endtask
  task automatic t_default;
    rw(22'h004010, 22'h004020, 8'h02, 1);
    rw(22'h004010, 22'h008000, 8'h09, 0);
    rw(22'h007fc0, 22'h003fff, 8'h02, 0);
  endtask
  task automatic t_disable;
    apb(1, wrop_pkg::DEV_CFG_ADDR, 32'h0000_0003);
    chk(order_guard_enable, 0);
    rw(22'h004010, 22'h004020, 8'h02, 0);
    rw(22'h004010, 22'h004010, 8'h05, 1);
    apb(1, wrop_pkg::DEV_CFG_ADDR, 32'h0008_0003);
    chk(order_guard_enable, 1);
  endtask
  task automatic t_program;
    // Start kept a multiple of the block size
    apb(1, wrop_pkg::START_ADDR, 32'h0000_0001);
    apb(1, wrop_pkg::SIZE_ADDR, 32'h0000_0000);
    rw(22'h000040, 22'h00007f, 8'h02, 1);
    rw(22'h000040, 22'h000080, 8'h02, 0);
    apb(1, wrop_pkg::START_ADDR, 32'h0000_0000);
    apb(1, wrop_pkg::SIZE_ADDR, 32'h0000_ffff);
    apb(0, wrop_pkg::SIZE_ADDR, 0);
    chk(rd, 32'h0000_ffff);
    rw(22'h000000, 22'h3fffff, 8'h03, 1);
    apb(0, 14'h2204, 0);
    chk(rd, 0);
    chk(err, 1);
  endtask
  task automatic t_status;
    // Stall count runs from first presentation of the read through the issue cycle
    apb(1, wrop_pkg::STATUS_ADDR, 0);
    apb(0, wrop_pkg::STATUS_ADDR, 0);
    chk(rd, 0);
    rw(22'h000000, 22'h000100, 8'h04, 1);
    apb(0, wrop_pkg::STATUS_ADDR, 0);
    chk(rd, 32'h0004_0000);
    reset_pin_status <= 1;
    apb(0, wrop_pkg::DEV_CFG_ADDR, 0);
    chk(rd, 32'h000f_006b);
    // Mid-run reset must bring back the guard and the default block
    apb(1, wrop_pkg::DEV_CFG_ADDR, 0);
    chk(order_guard_enable, 0);
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk(order_guard_enable, 1);
    apb(0, wrop_pkg::START_ADDR, 0);
    chk(rd, 32'h0000_0100);
    apb(0, wrop_pkg::SIZE_ADDR, 0);
    chk(rd, 32'h0000_00ff);
  endtask
  task automatic conclude;
    $display("errors=%0d compares=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_reset();
    t_default();
    t_disable();
    t_program();
    t_status();
    conclude();
  end
endmodule
bind wrop_guard wrop_guard_chk i_wrop_guard_chk (.*);
